// [dv/mmf_slave_model.sv]
`timescale 1ns/1ps
module mmf_slave_model (
   input  wire logic                                 mclk,
   input  wire logic                                 resetn,
   input  wire logic                                 slow,
   input  wire logic [1:0]                           s_chipselect,
   input  wire logic [1:0][mmf_pkg::MMF_SAW-1:0]     s_address,
   input  wire mmf_pkg::mmf_sreq_s                   s_req,
   output logic [1:0][mmf_pkg::MMF_DW-1:0]           s_readdata,
   output logic [1:0]                                s_waitrequest,
   output logic [1:0]                                s_readdatavalid
);
   import mmf_pkg::*;

   // ------------------------------------------------------------
   // Slave 0 plain, slave 1 fixed latency of two
   // ------------------------------------------------------------
   logic [MMF_DW-1:0]      mem0 [0:1023];
   logic [MMF_DW-1:0]      mem1 [0:1023];
   logic [1:0][1:0]        stall_reg;
   logic [1:0]             pipe_v;
   logic [1:0][MMF_DW-1:0] pipe_d;
   logic                   tick_reg;
   wire logic [1:0]        strobe = s_chipselect & {2{s_req.read | s_req.write}};
   wire logic [1:0]        take   = strobe & ~s_waitrequest;
   // Idle data toggles every cycle so a stale capture cannot pass by luck
   wire logic [MMF_DW-1:0] noise  = tick_reg ? 32'h5A5AA5A5 : 32'hA5A55A5A;

   assign s_waitrequest[0]  = slow & strobe[0] & (stall_reg[0] < 2'h2);
   assign s_waitrequest[1]  = slow & strobe[1] & (stall_reg[1] < 2'h2);
   assign s_readdata[0]     = (strobe[0] & s_req.read) ? mem0[s_address[0][9:0]] : noise;
   assign s_readdata[1]     = pipe_v[1] ? pipe_d[1] : noise;
   // Slave 1 flags its data, so it can also stand in for a variable latency slave
   assign s_readdatavalid   = {pipe_v[1], 1'b0};

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         stall_reg <= '0;
         pipe_v    <= '0;
         tick_reg  <= 1'b0;
      end else begin
         tick_reg     <= ~tick_reg;
         stall_reg[0] <= s_waitrequest[0] ? stall_reg[0] + 2'h1 : 2'h0;
         stall_reg[1] <= s_waitrequest[1] ? stall_reg[1] + 2'h1 : 2'h0;
         pipe_v[0]    <= take[1] & s_req.read;
         pipe_d[0]    <= mem1[s_address[1][9:0]];
         pipe_v[1]    <= pipe_v[0];
         pipe_d[1]    <= pipe_d[0];
      end
   end

   always_ff @(posedge mclk) begin
      if (take[0] & s_req.write) begin
         mem0[s_address[0][9:0]] <= s_req.writedata;
      end
      if (take[1] & s_req.write) begin
         mem1[s_address[1][9:0]] <= s_req.writedata;
      end
   end
endmodule : mmf_slave_model

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
   import mmf_pkg::*;

   logic                    mclk, resetn, slow, m_waitrequest, m_readdatavalid, prev_stb, prev_cs0;
   mmf_mreq_s               m_req;
   mmf_sreq_s               s_req;
   logic [MMF_DW-1:0]       m_readdata;
   logic [1:0]              s_chipselect, s_waitrequest, s_readdatavalid, arb_grant;
   logic [1:0][MMF_SAW-1:0] s_address;
   logic [1:0][MMF_DW-1:0]  s_readdata;
   mmf_mreq_s               np_req;
   mmf_sreq_s               np_sreq;
   logic                    np_wait, np_rvalid;
   logic [MMF_DW-1:0]       np_rdata;
   logic [1:0]              np_cs, np_swait, np_svalid;
   logic [1:0][MMF_SAW-1:0] np_addr;
   logic [1:0][MMF_DW-1:0]  np_srdata;
   int                      err_count, checks, cycles;
   logic [MMF_DW-1:0]       exp_q[$];
   logic [MMF_AW-1:0]       addr_q[$];
   logic [MMF_DW-1:0]       ref_mem [logic [MMF_AW-1:0]];

   mmf_fabric_port dut (.mclk(mclk), .resetn(resetn), .m_req(m_req), .m_waitrequest(m_waitrequest),
      .m_readdata(m_readdata), .m_readdatavalid(m_readdatavalid), .s_chipselect(s_chipselect),
      .s_address(s_address), .s_req(s_req), .s_readdata(s_readdata), .s_waitrequest(s_waitrequest),
      .s_readdatavalid(s_readdatavalid), .arb_grant(arb_grant));
   mmf_slave_model slv (.mclk(mclk), .resetn(resetn), .slow(slow), .s_chipselect(s_chipselect),
      .s_address(s_address), .s_req(s_req), .s_readdata(s_readdata), .s_waitrequest(s_waitrequest),
      .s_readdatavalid(s_readdatavalid));
   // Second port: plain master against a plain slave and a variable latency slave
   mmf_fabric_port #(.M_PIPE(1'b0), .SLV_KIND({2'h2, 2'h0})) dut_np (.mclk(mclk), .resetn(resetn),
      .m_req(np_req), .m_waitrequest(np_wait), .m_readdata(np_rdata), .m_readdatavalid(np_rvalid),
      .s_chipselect(np_cs), .s_address(np_addr), .s_req(np_sreq), .s_readdata(np_srdata),
      .s_waitrequest(np_swait), .s_readdatavalid(np_svalid), .arb_grant(arb_grant));
   mmf_slave_model slv_np (.mclk(mclk), .resetn(resetn), .slow(slow), .s_chipselect(np_cs),
      .s_address(np_addr), .s_req(np_sreq), .s_readdata(np_srdata), .s_waitrequest(np_swait),
      .s_readdatavalid(np_svalid));

   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   function automatic logic [MMF_DW-1:0] exp_rd(input logic [MMF_AW-1:0] a);
      if (a > MMF_DEF_END[1]) return MMF_UNMAPPED;
      return ref_mem[a];
   endfunction : exp_rd

   function automatic logic [MMF_AW-1:0] rnd_addr;
      return ($urandom_range(1) ? MMF_DEF_BASE[1] : MMF_DEF_BASE[0]) + 32'($urandom_range(1023) << 2);
   endfunction : rnd_addr

   // Request stays up until the edge that shows the stall gone; caller decides on release
   task automatic xfer(input logic wr, input logic [MMF_AW-1:0] a, input logic [MMF_DW-1:0] d);
      int n;
      n = 0;
      @(negedge mclk);
      m_req = '{read: !wr, write: wr, address: a, writedata: d};
      if (!wr) exp_q.push_back(exp_rd(a));
      if (wr && a <= MMF_DEF_END[1]) begin
         ref_mem[a] = d;
         addr_q.push_back(a);
      end
      do begin
         @(posedge mclk);
         n++;
      end while (m_waitrequest !== 1'b0 && n < 200);
      if (n >= 200) check(32'h1, 32'h0);
   endtask : xfer

   // Plain master: read data stands in the cycle the stall drops, never with a valid pulse
   task automatic xfer_np(input logic wr, input logic [MMF_AW-1:0] a, input logic [MMF_DW-1:0] d);
      int n;
      n = 0;
      @(negedge mclk);
      np_req = '{read: !wr, write: wr, address: a, writedata: d};
      do begin
         @(posedge mclk);
         n++;
         check(32'(np_rvalid), 32'h0);
      end while (np_wait !== 1'b0 && n < 200);
      if (n >= 200) check(32'h1, 32'h0);
      if (!wr) check(np_rdata, ref_mem[a]);
   endtask : xfer_np

   task automatic idle;
      @(negedge mclk);
      m_req.read  = 1'b0;
      m_req.write = 1'b0;
   endtask : idle

   task automatic drain;
      int n;
      idle();
      for (n = 0; n < 50 && exp_q.size() > 0; n++) @(posedge mclk);
      check(exp_q.size(), 0);
   endtask : drain

   // ------------------------------------------------------------
   // Port monitor
   // ------------------------------------------------------------
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         summarize();
      end
      if (resetn !== 1'b1) begin
         prev_stb = 1'b0;
         prev_cs0 = 1'b0;
      end else begin
         if (m_readdatavalid === 1'b1) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else check(m_readdata, exp_q.pop_front());
         end
         check(32'($countones(s_chipselect) <= 1), 32'h1);
         for (int i = 0; i < 2; i++) begin
            if (s_chipselect[i] === 1'b1) begin
               check(32'(m_req.address >= MMF_DEF_BASE[i] && m_req.address <= MMF_DEF_END[i]), 32'h1);
               check(32'(s_address[i]), (m_req.address - MMF_DEF_BASE[i]) >> MMF_WORD_SHIFT & 32'hFFFF);
            end
         end
         if (s_req.write === 1'b1) check(s_req.writedata, m_req.writedata);
         if (s_waitrequest !== 2'h0) check(32'(m_waitrequest), 32'h1);
         if (s_chipselect[0] & (s_req.read | s_req.write) & !prev_stb) check(32'(prev_cs0), 32'h1);
         if (prev_stb & !(s_req.read | s_req.write)) check(32'(s_chipselect[0]), 32'h1);
         prev_stb = s_chipselect[0] & (s_req.read | s_req.write);
         prev_cs0 = s_chipselect[0];
      end
   end

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      slow = 1'b0;
      arb_grant = 2'h3;
      m_req = '0;
      np_req = '0;
      err_count = 0;
      checks = 0;
      cycles = 0;
      void'($urandom(60870));
      repeat (10) @(posedge mclk);
      @(negedge mclk) resetn = 1'b1;
      for (int i = 0; i < 2; i++) begin
         xfer(1'b1, MMF_DEF_BASE[i], $urandom);
         xfer(1'b1, MMF_DEF_END[i] & 32'hFFFFFFFC, $urandom);
      end
      repeat (40) xfer(1'b1, rnd_addr(), $urandom);
      for (int s = 0; s < 2; s++) begin
         slow = s[0];
         repeat (60) xfer(1'b0, addr_q[$urandom_range(addr_q.size() - 1)], 32'h0);
         drain();
      end
      slow = 1'b0;
      xfer(1'b0, MMF_DEF_END[1] + 32'h1, 32'h0);
      xfer(1'b1, 32'hFFFFFFFC, $urandom);
      xfer(1'b0, 32'hFFFFFFFC, 32'h0);
      drain();
      // Unmapped read right behind a latency read must not overtake it
      xfer(1'b0, addr_q[2], 32'h0);
      xfer(1'b0, MMF_DEF_END[1] + 32'h1, 32'h0);
      drain();
      arb_grant = 2'h1;
      fork
         xfer(1'b0, addr_q[3], 32'h0);
         begin
            repeat (8) @(posedge mclk);
            check(32'(m_waitrequest), 32'h1);
            check(32'(s_chipselect), 32'h0);
            @(negedge mclk) arb_grant = 2'h3;
         end
      join
      drain();
      xfer(1'b0, addr_q[2], 32'h0);
      xfer(1'b0, addr_q[3], 32'h0);
      @(negedge mclk);
      resetn = 1'b0;
      m_req = '0;
      exp_q.delete();
      @(posedge mclk);
      check({m_waitrequest, m_readdatavalid, s_chipselect}, 32'h8);
      @(negedge mclk) resetn = 1'b1;
      repeat (6) @(posedge mclk) check(32'(m_readdatavalid), 32'h0);
      for (int i = 0; i < 4; i++) xfer(1'b0, addr_q[i], 32'h0);
      drain();
      for (int s = 0; s < 2; s++) begin
         slow = s[0];
         for (int i = 0; i < 4; i++) xfer_np(1'b1, addr_q[i], ref_mem[addr_q[i]]);
         for (int i = 0; i < 4; i++) xfer_np(1'b0, addr_q[i], 32'h0);
      end
      @(negedge mclk) np_req = '0;
      summarize();
   end
endmodule : tb

// [rtl/mmf_fabric_port.sv]
`timescale 1ns/1ps
module mmf_fabric_port #(
   parameter int                                     NS        = 2,
   parameter logic                                   M_PIPE    = 1'b1,
   parameter int                                     MAX_OUT   = mmf_pkg::MMF_DEF_OUT,
   parameter logic [NS-1:0][mmf_pkg::MMF_AW-1:0]     SLV_BASE  = mmf_pkg::MMF_DEF_BASE,
   parameter logic [NS-1:0][mmf_pkg::MMF_AW-1:0]     SLV_END   = mmf_pkg::MMF_DEF_END,
   parameter logic [NS-1:0][1:0]                     SLV_KIND  = mmf_pkg::MMF_DEF_KIND,
   parameter logic [NS-1:0][mmf_pkg::MMF_CNT_W-1:0]  SLV_SETUP = mmf_pkg::MMF_DEF_SETUP,
   parameter logic [NS-1:0][mmf_pkg::MMF_CNT_W-1:0]  SLV_HOLD  = mmf_pkg::MMF_DEF_HOLD,
   parameter logic [NS-1:0][mmf_pkg::MMF_CNT_W-1:0]  SLV_LAT   = mmf_pkg::MMF_DEF_LAT
) (
   input  wire logic                                 mclk,
   input  wire logic                                 resetn,
   input  wire mmf_pkg::mmf_mreq_s                   m_req,
   output logic                                      m_waitrequest,
   output logic [mmf_pkg::MMF_DW-1:0]                m_readdata,
   output logic                                      m_readdatavalid,
   output logic [NS-1:0]                             s_chipselect,
   output logic [NS-1:0][mmf_pkg::MMF_SAW-1:0]       s_address,
   output mmf_pkg::mmf_sreq_s                        s_req,
   input  wire logic [NS-1:0][mmf_pkg::MMF_DW-1:0]   s_readdata,
   input  wire logic [NS-1:0]                        s_waitrequest,
   input  wire logic [NS-1:0]                        s_readdatavalid,
   input  wire logic [NS-1:0]                        arb_grant
);
   import mmf_pkg::*;

   localparam int SW = (NS > 1) ? $clog2(NS) : 1;
   localparam int OW = $clog2(MAX_OUT + 1);

   typedef enum {
      ST_IDLE,
      ST_SETUP,
      ST_ACCESS,
      ST_HOLD,
      ST_WAIT_DATA,
      ST_DONE
   } mmf_state_e;

   mmf_state_e               state_reg;
   mmf_state_e               state_next;
   logic [SW-1:0]            sel_reg;
   logic [SW-1:0]            sel_next;
   logic [SW-1:0]            pend_sel_reg;
   logic                     rd_reg;
   logic                     rd_next;
   logic [MMF_CNT_W-1:0]     cnt_reg;
   logic [MMF_CNT_W-1:0]     cnt_next;
   logic [OW-1:0]            out_reg;
   logic [OW-1:0]            out_next;
   logic [NS-1:0]            hit;
   logic [NS-1:0]            rsp_tok;
   logic [NS-1:0]            lat_in;
   logic [NS-1:0][MMF_SAW-1:0] word;
   logic [SW-1:0]            new_idx;
   logic                     take;
   logic                     cap;
   logic                     push;
   logic                     unmapped;

   // ------------------------------------------------------------
   // Address decode, private to this master port
   // ------------------------------------------------------------
   for (genvar i = 0; i < NS; i++) begin : g_dec
      wire [MMF_AW-1:0] off = m_req.address - SLV_BASE[i];
      assign hit[i]  = (m_req.address >= SLV_BASE[i]) && (m_req.address <= SLV_END[i]);
      assign word[i] = off[MMF_WORD_SHIFT +: MMF_SAW];
      assign lat_in[i] = (state_reg == ST_ACCESS) && rd_reg && !s_waitrequest[i]
                         && (sel_reg == SW'(i));
      // Response tokens: delayed accept for fixed latency, slave flag for variable
      if (SLV_KIND[i] == MMF_KIND_FIXED) begin : g_fix
         mmf_lat_line #(.LAT(int'(SLV_LAT[i]))) u_lat (
            .mclk    (mclk),
            .resetn  (resetn),
            .tok_in  (lat_in[i]),
            .tok_out (rsp_tok[i])
         );
      end else if (SLV_KIND[i] == MMF_KIND_VAR) begin : g_var
         assign rsp_tok[i] = s_readdatavalid[i];
      end else begin : g_plain
         assign rsp_tok[i] = 1'b0;
      end
   end

   // Lowest matching slave wins, so overlapping ranges never raise two selects
   always_comb begin
      new_idx = '0;
      for (int i = NS - 1; i >= 0; i--) begin
         if (hit[i]) begin
            new_idx = SW'(i);
         end
      end
   end

   wire       any_req   = m_req.read || m_req.write;
   wire       any_hit   = |hit;
   wire [1:0] new_kind  = SLV_KIND[new_idx];
   wire [1:0] cur_kind  = SLV_KIND[sel_reg];
   wire       cur_pipe  = (cur_kind != MMF_KIND_PLAIN);
   wire       slv_ok    = !s_waitrequest[sel_reg];
   // Order is kept by only letting new reads join reads already in flight to the
   // same latency slave; a read elsewhere waits for the pipe to drain. Costs some
   // throughput when a master alternates slaves, but needs no reorder buffer.
   wire       order_ok  = !M_PIPE || !m_req.read || (out_reg == '0)
                          || ((new_idx == pend_sel_reg) && (new_kind != MMF_KIND_PLAIN)
                              && (out_reg != OW'(MAX_OUT)));
   wire       pop       = M_PIPE && (out_reg != '0) && rsp_tok[pend_sel_reg];

   // ------------------------------------------------------------
   // Wait-state machine
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      take       = 1'b0;
      cap        = 1'b0;
      push       = 1'b0;
      unmapped   = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (any_req && !any_hit) begin
               // An unmapped read still queues behind reads in flight, or it would overtake them
               if (!m_req.read || (out_reg == '0)) begin
                  unmapped   = 1'b1;
                  state_next = ST_DONE;
               end
            end else if (any_req && arb_grant[new_idx] && order_ok) begin
               take     = 1'b1;
               cnt_next = SLV_SETUP[new_idx];
               state_next = (SLV_SETUP[new_idx] != '0) ? ST_SETUP : ST_ACCESS;
            end
         end
         ST_SETUP: begin
            cnt_next = cnt_reg - MMF_CNT_W'(1);
            if (cnt_reg == MMF_CNT_W'(1)) begin
               state_next = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            if (slv_ok) begin
               cnt_next = SLV_HOLD[sel_reg];
               if (rd_reg && cur_pipe && !M_PIPE) begin
                  state_next = ST_WAIT_DATA;
               end else begin
                  push = rd_reg && cur_pipe;
                  cap  = rd_reg && !cur_pipe;
                  state_next = (SLV_HOLD[sel_reg] != '0) ? ST_HOLD : ST_DONE;
               end
            end
         end
         ST_HOLD: begin
            cnt_next = cnt_reg - MMF_CNT_W'(1);
            if (cnt_reg == MMF_CNT_W'(1)) begin
               state_next = ST_DONE;
            end
         end
         ST_WAIT_DATA: begin
            if (rsp_tok[sel_reg]) begin
               cap        = 1'b1;
               state_next = ST_DONE;
            end
         end
         ST_DONE: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   assign sel_next = take ? new_idx : sel_reg;
   assign rd_next  = take ? m_req.read : rd_reg;
   assign out_next = out_reg + OW'(push) - OW'(pop);

   wire in_xfer   = (state_next == ST_SETUP) || (state_next == ST_ACCESS) || (state_next == ST_HOLD);
   wire strobe    = (state_next == ST_ACCESS);
   wire rvalid_nx = M_PIPE && (pop || cap || (unmapped && m_req.read));
   wire [MMF_DW-1:0] rdata_nx = pop ? s_readdata[pend_sel_reg] :
                                cap ? s_readdata[sel_reg] : MMF_UNMAPPED;

   // ------------------------------------------------------------
   // State and output registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
         sel_reg   <= '0;
         rd_reg    <= 1'b0;
         cnt_reg   <= '0;
      end else begin
         state_reg <= state_next;
         sel_reg   <= sel_next;
         rd_reg    <= rd_next;
         cnt_reg   <= cnt_next;
      end
   end

   // Tracking exists only for a pipelined master; otherwise it folds to constants
   if (M_PIPE) begin : g_track
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            out_reg      <= '0;
            pend_sel_reg <= '0;
         end else begin
            out_reg <= out_next;
            if (push) begin
               pend_sel_reg <= sel_reg;
            end
         end
      end
   end else begin : g_notrack
      assign out_reg      = '0;
      assign pend_sel_reg = '0;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         m_waitrequest   <= MMF_WAIT_RST;
         m_readdata      <= MMF_RDATA_RST;
         m_readdatavalid <= 1'b0;
         s_chipselect    <= '0;
         s_address       <= '0;
         s_req           <= '0;
      end else begin
         m_waitrequest   <= (state_next != ST_DONE);
         m_readdatavalid <= rvalid_nx;
         if (pop || cap || unmapped) begin
            m_readdata <= rdata_nx;
         end
         s_chipselect <= in_xfer ? (NS'(1) << sel_next) : '0;
         s_req.read   <= strobe && rd_next;
         s_req.write  <= strobe && !rd_next;
         if (take) begin
            s_address       <= word;
            s_req.writedata <= m_req.writedata;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence s_plain_rd_accept;
      (state_reg == ST_ACCESS) && rd_reg && slv_ok && !cur_pipe;
   endsequence

   sequence s_answer;
      !m_waitrequest;
   endsequence

   a_cs_onehot: assert property ($onehot0(s_chipselect))
      else $error("more than one slave selected");
   a_strobe_has_cs: assert property ((s_req.read || s_req.write) |-> |s_chipselect)
      else $error("strobe without chipselect");
   a_slave_stall: assert property ((state_reg == ST_ACCESS) && !slv_ok |=> m_waitrequest)
      else $error("master released while slave waits");
   a_grant_stall: assert property ((state_reg == ST_IDLE) && any_req && any_hit && !arb_grant[new_idx]
                                   |=> m_waitrequest && (s_chipselect == '0))
      else $error("master served without grant");
   a_setup_cs: assert property ($rose(s_req.read || s_req.write) && (SLV_SETUP[sel_reg] != '0)
                                |-> $past(|s_chipselect))
      else $error("strobe without setup cycle");
   // Data must be right one cycle after the accept; the answer follows after the hold cycles
   a_plain_read: assert property (s_plain_rd_accept |=> (m_readdata == $past(s_readdata[sel_reg]))
                                  ##[0:15] s_answer)
      else $error("plain read data not returned");
   a_wait_release: assert property ((state_reg == ST_WAIT_DATA) |-> m_waitrequest
                                    && (s_chipselect == '0))
      else $error("latency wait holds slave or releases master");
   a_pop_data: assert property (pop |=> m_readdatavalid
                                && (m_readdata == $past(s_readdata[pend_sel_reg])))
      else $error("tracked read data not delivered");
   a_order_keep: assert property (take && m_req.read && (out_reg != '0)
                                  |-> (new_idx == pend_sel_reg))
      else $error("read issued past in-flight reads of another slave");
   a_map_range: assert property (take |-> (m_req.address >= SLV_BASE[new_idx])
                                 && (m_req.address <= SLV_END[new_idx]))
      else $error("slave taken outside its range");
   a_out_bound: assert property (out_reg <= OW'(MAX_OUT))
      else $error("outstanding reads beyond limit");

endmodule : mmf_fabric_port

// [rtl/mmf_lat_line.sv]
`timescale 1ns/1ps
module mmf_lat_line #(
   parameter int LAT = 1
) (
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic tok_in,
   output logic      tok_out
);
   // ------------------------------------------------------------
   // Token delay of exactly LAT cycles, one bit per cycle in flight
   // ------------------------------------------------------------
   logic [LAT-1:0] line_reg;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         line_reg <= '0;
      end else begin
         line_reg <= (line_reg << 1) | LAT'(tok_in);
      end
   end

   assign tok_out = line_reg[LAT-1];

endmodule : mmf_lat_line

// [rtl/mmf_pkg.sv]
package mmf_pkg;

   // ------------------------------------------------------------
   // Widths shared by the port structs
   // ------------------------------------------------------------
   localparam int MMF_AW         = 32;
   localparam int MMF_DW         = 32;
   localparam int MMF_SAW        = 16;
   localparam int MMF_WORD_SHIFT = 2;
   localparam int MMF_CNT_W      = 4;

   // ------------------------------------------------------------
   // Reset values and unmapped read data
   // ------------------------------------------------------------
   localparam logic              MMF_WAIT_RST  = 1'b1;
   localparam logic [MMF_DW-1:0] MMF_RDATA_RST = 32'h00000000;
   localparam logic [MMF_DW-1:0] MMF_UNMAPPED  = 32'h00000000;

   // ------------------------------------------------------------
   // Default map and timing of the two default slaves
   // ------------------------------------------------------------
   localparam logic [1:0][MMF_AW-1:0]    MMF_DEF_BASE  = {32'h00001000, 32'h00000000};
   localparam logic [1:0][MMF_AW-1:0]    MMF_DEF_END   = {32'h00001FFF, 32'h00000FFF};
   localparam logic [1:0][MMF_CNT_W-1:0] MMF_DEF_SETUP = {4'h0, 4'h1};
   localparam logic [1:0][MMF_CNT_W-1:0] MMF_DEF_HOLD  = {4'h0, 4'h1};
   localparam logic [1:0][MMF_CNT_W-1:0] MMF_DEF_LAT   = {4'h2, 4'h1};
   localparam int                        MMF_DEF_OUT   = 4;

   typedef enum logic [1:0] {
      MMF_KIND_PLAIN,
      MMF_KIND_FIXED,
      MMF_KIND_VAR
   } mmf_kind_e;

   localparam logic [1:0][1:0] MMF_DEF_KIND = {2'h1, 2'h0};

   typedef struct packed {
      logic              read;
      logic              write;
      logic [MMF_AW-1:0] address;
      logic [MMF_DW-1:0] writedata;
   } mmf_mreq_s;

   typedef struct packed {
      logic              read;
      logic              write;
      logic [MMF_DW-1:0] writedata;
   } mmf_sreq_s;

endpackage : mmf_pkg
